// ### common/fdd_drive_pkg.sv
package fdd_drive_pkg;
  typedef enum logic [1:0] {
    IDX_IDLE  = 2'b00,
    IDX_PULSE = 2'b01,
    IDX_WAIT  = 2'b10
  } idx_state_t;
endpackage

// ### common/fdd_drive_regs.svh
`ifndef FDD_DRIVE_REGS_SVH
`define FDD_DRIVE_REGS_SVH

// Index pulse width, ms and cycles at 200 MHz
`define IDX_PULSE_MS       4
`define CLK_MHZ            200
`define IDX_PULSE_CYC      (`IDX_PULSE_MS * 1000 * `CLK_MHZ)
// Track count and track 00
`define TRACK_W            7
`define TRACK_ZERO         7'h00
`define TRACK_LAST         7'h4F
// Read-data low pulse width in cycles
`define RD_PULSE_CYC       8'h28
`define RD_CNT_W           8
`define IDX_CNT_W          24
// Flux FIFO shape
`define FIFO_W             1
`define FIFO_DEPTH         8
`define FIFO_AW            3
// Synchroniser reset levels: active-low host pins idle high
`define SYNC_IDLE          19'h001FF

`endif

// ### common/flux_stream_if.sv
`timescale 1ns/1ps
interface flux_stream_if;
  logic valid;
  logic ready;
  logic data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ### dv/fdd_host_model.sv
`timescale 1ns/1ps
module fdd_host_model #(
  parameter int SIDE_WAIT = 40,  // Shortened side settle, keeps the run brief
  parameter int DIR_SETUP = 200  // 1 us at 200 MHz
) (
  input  wire logic       mclk,
  output logic            side_n,
  output logic            head_load_n,
  output logic [3:0]      select_n,
  output logic            step_n,
  output logic            dir_n,
  output logic            write_gate_n
);
  initial begin
    side_n       = 1'b1;
    head_load_n  = 1'b1;
    select_n     = 4'hF;
    step_n       = 1'b1;
    dir_n        = 1'b1;
    write_gate_n = 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic sel(input logic [3:0] v);
    @(posedge mclk);
    #1 select_n = v;
  endtask

  task automatic load(input logic v);
    @(posedge mclk);
    #1 head_load_n = v;
  endtask

  task automatic wgate(input logic v);
    @(posedge mclk);
    #1 write_gate_n = v;
  endtask

  // Side change, then the settle wait before any read or write
  task automatic side(input logic v);
    @(posedge mclk);
    #1 side_n = v;
    repeat (SIDE_WAIT) @(posedge mclk);
  endtask

  // Direction is set well ahead of the falling step edge
  task automatic step(input logic out_n);
    @(posedge mclk);
    #1 dir_n = out_n;
    repeat (DIR_SETUP) @(posedge mclk);
    #1 step_n = 1'b0;
    repeat (4) @(posedge mclk);
    #1 step_n = 1'b1;
  endtask
endmodule

// ### dv/minifloppy_drive_interface_tb.sv
`timescale 1ns/1ps
`include "fdd_drive_regs.svh"
module minifloppy_drive_interface_tb;
  logic       mclk = 1'b0;
  logic       reset_n = 1'b0;
  logic       side_n, head_load_n, step_n, dir_n, write_gate_n;
  logic [3:0] select_n;
  logic       ready_n, track0_n, index_n, read_data_n, protect_n;
  logic [3:0] strap;
  logic       sig_strap, auto_strap, disk_present, disk_protected;
  logic       index_hole, flux_rev;
  logic       head1_en, head_loaded, activity_led, write_enable;
  logic [6:0] track;
  int         n_mismatch = 0;
  int         cmp_count = 0;
  int         seed = 29842;
  int         trk, i, n;
  int         r, nf, exp_low, base;
  int         low_cnt = 0;
  int         exp_q[$];
  logic       sel_m, rdy_m, load_m;

  always #2.5 mclk = ~mclk;

  // Read-data low cycles, counted at each rising edge
  always @(posedge mclk) begin
    if (read_data_n === 1'b0) begin
      low_cnt++;
    end
  end

  fdd_host_model u_host (.mclk(mclk), .side_n(side_n), .head_load_n(head_load_n),
    .select_n(select_n), .step_n(step_n), .dir_n(dir_n), .write_gate_n(write_gate_n));

  fdd_drive_if u_fdd_drive_if (.mclk(mclk), .reset_n(reset_n), .side_n(side_n),
    .head_load_n(head_load_n), .select_n(select_n), .step_n(step_n), .dir_n(dir_n),
    .write_gate_n(write_gate_n), .ready_n(ready_n), .track0_n(track0_n),
    .index_n(index_n), .read_data_n(read_data_n), .protect_n(protect_n),
    .rank_strap_one(strap[0]), .rank_strap_two(strap[1]), .rank_strap_three(strap[2]),
    .rank_strap_four(strap[3]), .signal_head_engage_strap(sig_strap),
    .auto_head_engage_strap(auto_strap), .disk_present(disk_present),
    .disk_protected(disk_protected), .index_hole(index_hole), .flux_rev(flux_rev),
    .head1_en(head1_en), .head_loaded(head_loaded), .activity_led(activity_led),
    .write_enable(write_enable), .track(track));

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_trk(input logic [6:0] got, input logic [6:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("compares=%0d mismatches=%0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Outputs settle within 4 cycles of an input change
  task automatic wt(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask

  // Hang guard
  initial begin
    repeat (90000) @(posedge mclk);
    n_mismatch++;
    results();
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    strap          = 4'h1;
    sig_strap      = 1'b1;
    auto_strap     = 1'b0;
    disk_present   = 1'b0;
    disk_protected = 1'b0;
    index_hole     = 1'b0;
    flux_rev       = 1'b0;
    wt(3);
    reset_n = 1'b1;
    wt(4);
    chk(ready_n, 1'b1);
    chk(index_n, 1'b1);
    u_host.sel(4'hE);
    wt(6);
    chk(ready_n, 1'b1);
    chk(index_n, 1'b0);
    disk_present = 1'b1;
    wt(6);
    chk(ready_n, 1'b0);
    chk(index_n, 1'b1);
    // Every strap against every select line
    for (i = 0; i < 4; i++) begin
      strap = 4'h1 << i;
      for (n = 0; n < 4; n++) begin
        u_host.sel(~(4'h1 << n));
        wt(6);
        chk(ready_n, i != n);
      end
    end
    strap = 4'h1;
    u_host.sel(4'hE);
    // Climb past the last track, wander, then back past track 00
    trk = 0;
    for (i = 0; i < 186; i++) begin
      n = (i < 82) ? 0 : (i < 100) ? ($random(seed) & 1) : 1;
      u_host.step(n[0]);
      wt(6);
      trk = n ? ((trk > 0) ? trk - 1 : 0) : ((trk < 79) ? trk + 1 : 79);
      chk_trk(track, trk[6:0]);
      chk(track0_n, trk != 0);
    end
    u_host.side(1'b0);
    wt(6);
    chk(head1_en, 1'b1);
    u_host.side(1'b1);
    wt(6);
    chk(head1_en, 1'b0);
    chk(head_loaded, 1'b0);
    u_host.load(1'b0);
    wt(6);
    chk(head_loaded, 1'b1);
    chk(activity_led, 1'b1);
    u_host.wgate(1'b0);
    u_host.step(1'b0);
    wt(6);
    chk_trk(track, trk[6:0]);
    chk(write_enable, 1'b1);
    disk_protected = 1'b1;
    wt(6);
    chk(protect_n, 1'b0);
    chk(write_enable, 1'b0);
    u_host.wgate(1'b1);
    disk_protected = 1'b0;
    disk_present = 1'b0;
    wt(6);
    chk(head_loaded, 1'b0);
    chk(activity_led, 1'b0);
    disk_present = 1'b1;
    u_host.load(1'b1);
    sig_strap = 1'b0;
    auto_strap = 1'b1;
    wt(6);
    chk(head_loaded, 1'b1);
    u_host.sel(4'hF);
    wt(6);
    chk(head_loaded, 1'b0);
    chk(ready_n, 1'b1);
    u_host.sel(4'hE);
    index_hole = 1'b1;
    wt(3);
    index_hole = 1'b0;
    wt(5);
    chk(index_n, 1'b0);
    wt(100);
    chk(index_n, 1'b0);
    // Three reversals two cycles apart, each owed a 40-cycle low pulse
    n = 0;
    for (i = 0; i < 260; i++) begin
      flux_rev = (i < 6) && !i[0];
      wt(1);
      n += (read_data_n === 1'b0);
    end
    chk_trk(n[6:0], 7'h78);
    chk(read_data_n, 1'b1);
    // Mid-run reset ends the long index pulse and rebuilds the idle state
    reset_n = 1'b0;
    wt(3);
    reset_n = 1'b1;
    wt(6);
    chk(index_n, 1'b1);
    chk(track0_n, 1'b0);
    chk_trk(track, `TRACK_ZERO);
    chk(head_loaded, 1'b1);
    // Random burst of one to eight reversals, never more than the FIFO holds
    base = low_cnt;
    nf = 1 + ($random(seed) & 7);
    for (i = 0; i < nf; i++) begin
      flux_rev = 1'b1;
      wt(1);
      flux_rev = 1'b0;
      exp_q.push_back(`RD_PULSE_CYC);
      wt(1 + ($random(seed) & 3));
    end
    wt(360);
    exp_low = 0;
    while (exp_q.size() > 0) begin
      exp_low += exp_q.pop_front();
    end
    chk_cnt(16'(low_cnt - base), 16'(exp_low));
    // Random straps, disk state and host levels against the rule model
    for (i = 0; i < 32; i++) begin
      r              = $random(seed);
      strap          = 4'h1 << r[1:0];
      sig_strap      = r[2];
      auto_strap     = r[8];
      disk_present   = r[3];
      disk_protected = r[4];
      u_host.sel(~(4'h1 << r[6:5]));
      u_host.load(r[7]);
      u_host.wgate(r[9]);
      wt(6);
      sel_m  = (r[1:0] == r[6:5]);
      rdy_m  = sel_m && r[3];
      load_m = rdy_m && ((r[8] && !r[2]) || !r[7]);
      chk(ready_n, !rdy_m);
      chk(index_n, !(sel_m && !r[3]));
      chk(protect_n, !(rdy_m && r[4]));
      chk(track0_n, !sel_m);
      chk(head_loaded, load_m);
      chk(activity_led, load_m);
      chk(write_enable, load_m && !r[9] && !r[4]);
      chk(read_data_n, 1'b1);
    end
    results();
  end
endmodule

// ### verilog/fdd_drive_if.sv
`timescale 1ns/1ps
`include "fdd_drive_regs.svh"
// Functional notes
// - Side choice low enables head 1, high enables head 0.
// - Ready is low only while a diskette is in and the drive is selected.
// - Track-zero is low while the drive is selected and the carriage sits at track 00.
// - Index rests high and pulses low for about 4 ms at each hole.
// - Index stays low while no diskette is inserted.
// - Read data idles high and pulses low at each flux reversal while write gate is high.
// - A protected diskette drives protect low and blocks writes internally.
// - Straps pick exactly one select line as rank; default rank 1 with head-load input.
// - With the auto strap and no signal strap, heads load when ready and selected, ignoring head-load.
// - The activity indicator lights while the heads are loaded.
// - Direction high steps outward, low inward; host sets it 1 us before each step.
// - Each step pulse moves one track, none past track 00 or the last track; steps are ignored while write gate is low.
// - Only the drive whose strapped select is active accepts inputs or drives outputs.
// - Heads load on head-load low and release on high, only while ready is low.
module fdd_drive_if
  import fdd_drive_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // Host cable, active low
  input  wire logic       side_n,
  input  wire logic       head_load_n,
  input  wire logic [3:0] select_n,
  input  wire logic       step_n,
  input  wire logic       dir_n,
  input  wire logic       write_gate_n,
  output logic            ready_n,
  output logic            track0_n,
  output logic            index_n,
  output logic            read_data_n,
  output logic            protect_n,
  // Straps, high when fitted
  input  wire logic       rank_strap_one,
  input  wire logic       rank_strap_two,
  input  wire logic       rank_strap_three,
  input  wire logic       rank_strap_four,
  input  wire logic       signal_head_engage_strap,
  input  wire logic       auto_head_engage_strap,
  // Mechanism sensors and actuators
  input  wire logic       disk_present,
  input  wire logic       disk_protected,
  input  wire logic       index_hole,
  input  wire logic       flux_rev,
  output logic            head1_en,
  output logic            head_loaded,
  output logic            activity_led,
  output logic            write_enable,
  output logic [`TRACK_W-1:0] track
);
  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for all pins, one generate loop
  // Reset to idle levels, so no false step or select edge follows reset
  localparam int            NS   = 19;
  localparam logic [NS-1:0] IDLE = `SYNC_IDLE;
  logic [NS-1:0] raw, s1_q, s2_q;
  assign raw = {auto_head_engage_strap, signal_head_engage_strap, flux_rev, index_hole,
                disk_protected, disk_present, rank_strap_four,
                rank_strap_three, rank_strap_two, rank_strap_one, write_gate_n,
                dir_n, step_n, select_n, head_load_n, side_n};
  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : g_sync
      always_ff @(posedge mclk) begin
        if (!reset_n) begin
          s1_q[g] <= IDLE[g];
          s2_q[g] <= IDLE[g];
        end else begin
          s1_q[g] <= raw[g];
          s2_q[g] <= s1_q[g];
        end
      end
    end
  endgenerate

  logic       side_s, hl_s, step_s, dir_s, wg_s, prot_s, pres_s, hole_s, flux_s;
  logic       sig_s, auto_s;
  logic [3:0] sel_s, rank_s;
  assign side_s = s2_q[0];
  assign hl_s   = s2_q[1];
  assign sel_s  = s2_q[5:2];
  assign step_s = s2_q[6];
  assign dir_s  = s2_q[7];
  assign wg_s   = s2_q[8];
  assign rank_s = s2_q[12:9];
  assign pres_s = s2_q[13];
  assign prot_s = s2_q[14];
  assign hole_s = s2_q[15];
  assign flux_s = s2_q[16];
  assign sig_s  = s2_q[17];
  assign auto_s = s2_q[NS-1];

  ////////////////////////////////////////////////////////////////////////////
  // Selection, head control, stepping and status outputs; index and read data in auxiliary always_ff
  logic                 step_prev_q, step_prev_d, hole_prev_q, hole_prev_d;
  logic [`TRACK_W-1:0]  track_q, track_d;
  logic                 selected, ready_c, load_c, auto_mode;
  logic                 head1_q, head1_d, load_q, load_d, wen_q, wen_d;
  logic                 ready_q, ready_d, t0_q, t0_d, prot_q, prot_d;

  always_comb begin
    // Strap block holds one rank; a bad strap set falls back to rank 1
    case (rank_s)
      4'b0001: selected = !sel_s[0];
      4'b0010: selected = !sel_s[1];
      4'b0100: selected = !sel_s[2];
      4'b1000: selected = !sel_s[3];
      default: selected = !sel_s[0];
    endcase
    auto_mode = auto_s && !sig_s;
    ready_c   = pres_s && selected;
    // Load only while ready; auto strap without signal strap ignores the head-load input
    load_c    = ready_c && (auto_mode || !hl_s);
    step_prev_d = step_s;
    hole_prev_d = hole_s;
    track_d     = track_q;
    // Falling step edge, selected, write gate high
    if (selected && step_prev_q && !step_s && wg_s) begin
      if (dir_s) begin
        if (track_q != `TRACK_ZERO) track_d = track_q - `TRACK_W'(1);
      end else begin
        if (track_q != `TRACK_LAST) track_d = track_q + `TRACK_W'(1);
      end
    end
    head1_d = selected ? !side_s : head1_q;
    load_d  = load_c;
    wen_d   = selected && !wg_s && !prot_s && load_c;
    ready_d = !ready_c;
    t0_d    = !(selected && track_q == `TRACK_ZERO);
    prot_d  = !(selected && pres_s && prot_s);
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      step_prev_q <= 1'b1;
      hole_prev_q <= 1'b0;
      track_q     <= `TRACK_ZERO;
      head1_q     <= 1'b0;
      load_q      <= 1'b0;
      wen_q       <= 1'b0;
      ready_q     <= 1'b1;
      t0_q        <= 1'b1;
      prot_q      <= 1'b1;
    end else begin
      step_prev_q <= step_prev_d;
      hole_prev_q <= hole_prev_d;
      track_q     <= track_d;
      head1_q     <= head1_d;
      load_q      <= load_d;
      wen_q       <= wen_d;
      ready_q     <= ready_d;
      t0_q        <= t0_d;
      prot_q      <= prot_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Index pulse timer
  idx_state_t             idx_q, idx_d;
  logic [`IDX_CNT_W-1:0]  icnt_q, icnt_d;
  logic                   index_q, index_d;

  always_comb begin
    idx_d  = idx_q;
    icnt_d = icnt_q;
    case (idx_q)
      IDX_IDLE: begin
        if (hole_s && !hole_prev_q) begin
          idx_d  = IDX_PULSE;
          icnt_d = `IDX_CNT_W'(`IDX_PULSE_CYC - 1);
        end
      end
      IDX_PULSE: begin
        if (icnt_q == '0) idx_d = IDX_WAIT;
        else icnt_d = icnt_q - `IDX_CNT_W'(1);
      end
      IDX_WAIT: begin
        // Wait for the hole to pass so one hole gives one pulse
        if (!hole_s) idx_d = IDX_IDLE;
      end
      default: idx_d = IDX_IDLE;
    endcase
    if (!pres_s) idx_d = IDX_IDLE;
    if (!selected) index_d = 1'b1;
    else if (!pres_s) index_d = 1'b0;
    else index_d = (idx_d != IDX_PULSE);
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      idx_q   <= IDX_IDLE;
      icnt_q  <= '0;
      index_q <= 1'b1;
    end else begin
      idx_q   <= idx_d;
      icnt_q  <= icnt_d;
      index_q <= index_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flux events queue through the FIFO; drain stalls during each pulse
  flux_stream_if fx_in ();
  flux_stream_if fx_out ();
  logic                 flux_prev_q, flux_prev_d;
  logic [`RD_CNT_W-1:0] rcnt_q, rcnt_d;
  logic                 rd_q, rd_d;

  assign fx_in.valid = flux_s && !flux_prev_q && selected && wg_s;
  assign fx_in.data  = 1'b1;

  flux_fifo u_fifo (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .in_valid  (fx_in.valid),
    .in_data   (fx_in.data),
    .in_ready  (fx_in.ready),
    .out_valid (fx_out.valid),
    .out_data  (fx_out.data),
    .out_ready (fx_out.ready)
  );

  // Drain only when the output pulse timer is idle
  assign fx_out.ready = (rcnt_q == '0);

  always_comb begin
    flux_prev_d = flux_s;
    rcnt_d      = rcnt_q;
    if (fx_out.valid && fx_out.ready && fx_out.data) begin
      rcnt_d = `RD_PULSE_CYC;
    end else if (rcnt_q != '0) begin
      rcnt_d = rcnt_q - `RD_CNT_W'(1);
    end
    rd_d = !(selected && rcnt_d != '0);
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      flux_prev_q <= 1'b0;
      rcnt_q      <= '0;
      rd_q        <= 1'b1;
    end else begin
      flux_prev_q <= flux_prev_d;
      rcnt_q      <= rcnt_d;
      rd_q        <= rd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign ready_n      = ready_q;
  assign track0_n     = t0_q;
  assign index_n      = index_q;
  assign read_data_n  = rd_q;
  assign protect_n    = prot_q;
  assign head1_en     = head1_q;
  assign head_loaded  = load_q;
  assign activity_led = load_q;
  assign write_enable = wen_q;
  assign track        = track_q;

  ////////////////////////////////////////////////////////////////////////////
  property p_ready;
    @(posedge mclk) disable iff (!reset_n)
      (pres_s && selected) |=> !ready_n;
  endproperty
  a_ready: assert property (p_ready) else $error("ready not low");

  property p_t0;
    @(posedge mclk) disable iff (!reset_n)
      (selected && track_q == `TRACK_ZERO) |=> !track0_n;
  endproperty
  a_t0: assert property (p_t0) else $error("track0 not low");

  property p_nodisk;
    @(posedge mclk) disable iff (!reset_n)
      (selected && !pres_s) |=> !index_n;
  endproperty
  a_nodisk: assert property (p_nodisk) else $error("index not low without disk");

  property p_idx;
    @(posedge mclk) disable iff (!reset_n)
      (idx_q == IDX_IDLE && hole_s && !hole_prev_q && pres_s && selected)
        |=> !index_n [*8];
  endproperty
  a_idx: assert property (p_idx) else $error("index pulse short");

  property p_prot;
    @(posedge mclk) disable iff (!reset_n)
      prot_s |=> !write_enable;
  endproperty
  a_prot: assert property (p_prot) else $error("write on protected disk");

  property p_wgstep;
    @(posedge mclk) disable iff (!reset_n)
      !wg_s |=> $stable(track_q);
  endproperty
  a_wgstep: assert property (p_wgstep) else $error("step during write");

  property p_desel;
    @(posedge mclk) disable iff (!reset_n)
      !selected |=> (ready_n && track0_n && index_n && protect_n && read_data_n);
  endproperty
  a_desel: assert property (p_desel) else $error("deselected output active");

  property p_load;
    @(posedge mclk) disable iff (!reset_n)
      head_loaded |-> $past(ready_c) && activity_led;
  endproperty
  a_load: assert property (p_load) else $error("load without ready");

endmodule

// ### verilog/flux_fifo.sv
`timescale 1ns/1ps
`include "fdd_drive_regs.svh"
module flux_fifo #(
  parameter int WIDTH = `FIFO_W,
  parameter int DEPTH = `FIFO_DEPTH,
  parameter int AW    = `FIFO_AW
) (
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  always_comb begin
    push     = in_valid && in_ready;
    pop      = out_valid && out_ready;
    in_ready = (cnt_q != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    out_valid = (cnt_q != '0);
    out_data = mem_q[rd_q];
    mem_d    = mem_q;
    wr_d     = wr_q;
    rd_d     = rd_q;
    if (push) begin
      mem_d[wr_q] = in_data;
      wr_d        = wr_q + AW'(1);
    end
    if (pop) begin
      rd_d = rd_q + AW'(1);
    end
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
      mem_q <= mem_d;
    end
  end
endmodule
